// ==== common/xrc_regs.vh ====
`ifndef XRC_REGS_VH
`define XRC_REGS_VH

// ==========================================================
// bus offsets (byte addresses, 32-bit words)
`define XRC_CTRL 8'h00
`define XRC_STATUS 8'h04
`define XRC_HELD 8'h08
`define XRC_CTX_BASE 8'h80

// ==========================================================
// control register bits (write)
`define XRC_CTRL_START 0
`define XRC_CTRL_CLR_PCLK 1
`define XRC_CTRL_CLR_IPROC 2

// ==========================================================
// context package word indices
`define XRC_W_PC 4'h0
`define XRC_W_CODE_BASE 4'h1
`define XRC_W_CODE_LIMIT 4'h2
`define XRC_W_DATA_BASE 4'h3
`define XRC_W_DATA_LIMIT 4'h4
`define XRC_W_XBLOCK 4'h5
`define XRC_W_MODES 4'h6

// ==========================================================
// fields of the modes word
`define XRC_M_PRG_MODE 0
`define XRC_M_OPR_MODE 1
`define XRC_M_SUPERVISOR 2
`define XRC_M_NATIVE 3
`define XRC_M_EIM 4
`define XRC_M_PRG_FLAG 8
`define XRC_M_OPR_FLAG 9

// ==========================================================
// held interrupt bits
`define XRC_H_PRG 0
`define XRC_H_OPR 1
`define XRC_H_PCLK 2
`define XRC_H_IPROC 3

// ==========================================================
// sizes and reset values
`define XRC_PKG_WORDS 16
`define XRC_LAST_WORD 4'hf
`define XRC_COMPAT_PC_BITS 24
`define XRC_CTX_RESET 64'h0000_0000_0000_0000

`endif

// ==== design/exchange_and_range_check.v ====
`timescale 1ns/10ps
// Function
// - exchange loads incoming package into registers while writing outgoing one back.
// - swap starts only once computation stops, then walks words in fixed order.
// - every exchange does exactly sixteen reads and sixteen writes.
// - one sixteen-word block is both source and destination; word i swaps with i.
// - block location comes from exchange block address, a field of the package.
// - package holds address and scalar registers only; others are not kept.
// - an instruction block fetch starts right after the exchange completes.
// - issue selects the parcel at program counter, only when resources are free.
// - program counter advances on issue; missing instruction starts a new fetch.
// - program counter is 32 bits; low two bits pick a 16-bit parcel.
// - native mode spans one gigaword, compatibility mode four megawords.
// - restored program counter is the first instruction issued on resume.
// - fetch address is code base plus upper thirty program counter bits in native mode, bits 23..2 in compatibility mode.
// - fetch address outside code base..code limit is a program range error.
// - program range error always interrupts; flag only with its mode bit.
// - data absolute address is data base plus instruction address.
// - data address outside base..limit is operand error; mode sets flag, interrupt.
// - out-of-range read still completes but returns zero.
// - out-of-range write issues but the memory write is suppressed.
// - exchange to user mode sets global enable; to supervisor clears it.
// - exchange clears held interrupts except programmable clock and interprocessor.
`include "xrc_regs.vh"

module exchange_and_range_check #(
  parameter BUF_WORDS = 8,
  parameter BUF_LOG = 3
) (
  input wire clk,
  input wire reset,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output reg memReq,
  output reg memWe,
  output reg [31:0] memAddr,
  output reg [63:0] memWdata,
  input wire memRvalid,
  input wire [63:0] memRdata,
  input wire computeBusy,
  input wire issueReady,
  output reg issueValid,
  output reg [15:0] issueParcel,
  input wire dataReq,
  input wire dataWe,
  input wire [31:0] dataAddr,
  input wire [63:0] dataWdata,
  output reg dataReady,
  output reg dataRvalid,
  output reg [63:0] dataRdata,
  input wire pclkIrq,
  input wire iprocIrq,
  output reg irqOut
);

  // ==========================================================
  // states
  localparam S_IDLE = 3'd0;
  localparam S_XWAIT = 3'd1;
  localparam S_XRD = 3'd2;
  localparam S_XRW = 3'd3;
  localparam S_FETCH = 3'd4;
  localparam S_FWAIT = 3'd5;
  localparam S_RUN = 3'd6;
  localparam S_DWAIT = 3'd7;

  // ==========================================================
  // storage
  reg [63:0] ctx [0:15];
  reg [63:0] ibuf [0:BUF_WORDS-1];
  reg [2:0] state;
  reg [3:0] xIdx;
  reg [31:0] xBase;
  reg [BUF_LOG-1:0] fIdx;
  reg [29:0] bufTag;
  reg bufValid;
  reg [3:0] heldIrq;
  reg dZero;
  reg pendX;
  integer i;

  // ==========================================================
  // helpers
  function inRange;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      inRange = (a >= lo) && (a <= hi);
    end
  endfunction

  wire [63:0] modes = ctx[`XRC_W_MODES];
  wire native = modes[`XRC_M_NATIVE];
  wire [31:0] pc = ctx[`XRC_W_PC][31:0];
  // compat mode keeps only the 4-megaword span of the counter
  wire [29:0] pcWord = native ? pc[31:2] : {8'h00, pc[23:2]};
  wire [29:0] blockWord = {pcWord[29:BUF_LOG], {BUF_LOG{1'b0}}};
  wire [31:0] codeBase = ctx[`XRC_W_CODE_BASE][31:0];
  wire [31:0] fetchAbs = codeBase + {2'b00, blockWord} + {29'd0, fIdx};
  wire fetchOk = inRange(fetchAbs, codeBase, ctx[`XRC_W_CODE_LIMIT][31:0]);
  wire [31:0] dBase = ctx[`XRC_W_DATA_BASE][31:0];
  wire [31:0] dataAbs = dBase + dataAddr;
  wire dataOk = inRange(dataAbs, dBase, ctx[`XRC_W_DATA_LIMIT][31:0]);
  wire present = bufValid && (bufTag == blockWord);
  wire [63:0] curWord = ibuf[pcWord[BUF_LOG-1:0]];
  wire [31:0] pcNext = native ? pc + 32'h0000_0001 :
                       {8'h00, pc[23:0] + 24'h00_0001};
  wire oprMode = modes[`XRC_M_OPR_MODE];
  wire ctlWr = wr && (addr == `XRC_CTRL);
  wire ctxWr = wr && addr[7] && (state == S_IDLE);
  wire [3:0] ctxIdx = addr[6:3];

  // ==========================================================
  // bus read, one cycle later
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      if (addr[7]) begin
        rdata <= addr[2] ? ctx[ctxIdx][63:32] : ctx[ctxIdx][31:0];
      end else if (addr == `XRC_STATUS) begin
        rdata <= {24'h00_0000, bufValid, pendX, 3'b000, state};
      end else if (addr == `XRC_HELD) begin
        rdata <= {28'h000_0000, heldIrq};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // held interrupts and interrupt line
  reg [3:0] next_heldIrq;
  always @* begin
    next_heldIrq = heldIrq;
    if (state == S_XRW && memRvalid && xIdx == `XRC_LAST_WORD) begin
      next_heldIrq[`XRC_H_PRG] = 1'b0;
      next_heldIrq[`XRC_H_OPR] = 1'b0;
    end
    if (ctlWr && wdata[`XRC_CTRL_CLR_PCLK]) begin
      next_heldIrq[`XRC_H_PCLK] = 1'b0;
    end
    if (ctlWr && wdata[`XRC_CTRL_CLR_IPROC]) begin
      next_heldIrq[`XRC_H_IPROC] = 1'b0;
    end
    // a set in the clearing cycle wins
    if (pclkIrq) begin
      next_heldIrq[`XRC_H_PCLK] = 1'b1;
    end
    if (iprocIrq) begin
      next_heldIrq[`XRC_H_IPROC] = 1'b1;
    end
    if (state == S_FWAIT && !fetchOk) begin
      next_heldIrq[`XRC_H_PRG] = 1'b1;
    end
    if (state == S_RUN && dataReq && !dataOk && oprMode) begin
      next_heldIrq[`XRC_H_OPR] = 1'b1;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      heldIrq <= 4'h0;
      irqOut <= 1'b0;
    end else begin
      heldIrq <= next_heldIrq;
      irqOut <= |next_heldIrq;
    end
  end

  // ==========================================================
  // sequencer: exchange, fetch, issue, data references
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < `XRC_PKG_WORDS; i = i + 1) begin
        ctx[i] <= `XRC_CTX_RESET;
      end
      for (i = 0; i < BUF_WORDS; i = i + 1) begin
        ibuf[i] <= 64'h0000_0000_0000_0000;
      end
      state <= S_IDLE;
      xIdx <= 4'h0;
      xBase <= 32'h0000_0000;
      fIdx <= {BUF_LOG{1'b0}};
      bufTag <= 30'h0000_0000;
      bufValid <= 1'b0;
      dZero <= 1'b0;
      pendX <= 1'b0;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= 32'h0000_0000;
      memWdata <= 64'h0000_0000_0000_0000;
      issueValid <= 1'b0;
      issueParcel <= 16'h0000;
      dataReady <= 1'b0;
      dataRvalid <= 1'b0;
      dataRdata <= 64'h0000_0000_0000_0000;
    end else begin
      memReq <= 1'b0;
      memWe <= 1'b0;
      issueValid <= 1'b0;
      dataRvalid <= 1'b0;
      dataReady <= 1'b0;
      if (ctxWr) begin
        if (addr[2]) begin
          ctx[ctxIdx][63:32] <= wdata;
        end else begin
          ctx[ctxIdx][31:0] <= wdata;
        end
      end
      case (state)
        S_IDLE: begin
          if (ctlWr && wdata[`XRC_CTRL_START]) begin
            state <= S_XWAIT;
          end
        end
        S_XWAIT: begin
          // no outstanding reads here; only wait for the pipes to drain
          if (!computeBusy) begin
            xIdx <= 4'h0;
            xBase <= ctx[`XRC_W_XBLOCK][31:0];
            pendX <= 1'b0;
            state <= S_XRD;
          end
        end
        S_XRD: begin
          memReq <= 1'b1;
          memAddr <= xBase + {28'h000_0000, xIdx};
          state <= S_XRW;
        end
        S_XRW: begin
          if (memRvalid) begin
            // write the outgoing word before it is overwritten
            memReq <= 1'b1;
            memWe <= 1'b1;
            memAddr <= xBase + {28'h000_0000, xIdx};
            memWdata <= ctx[xIdx];
            ctx[xIdx] <= memRdata;
            xIdx <= xIdx + 4'h1;
            if (xIdx == `XRC_LAST_WORD) begin
              // modes word already loaded; only its enable bit is rewritten
              ctx[`XRC_W_MODES][`XRC_M_EIM] <= ~ctx[`XRC_W_MODES][`XRC_M_SUPERVISOR];
              bufValid <= 1'b0;
              fIdx <= {BUF_LOG{1'b0}};
              state <= S_FETCH;
            end else begin
              state <= S_XRD;
            end
          end
        end
        S_FETCH: begin
          // no request out of range, so no stray answer reaches the exchange
          memReq <= fetchOk;
          memAddr <= fetchAbs;
          state <= S_FWAIT;
        end
        S_FWAIT: begin
          if (!fetchOk) begin
            // range error always leads to an exchange
            if (modes[`XRC_M_PRG_MODE]) begin
              ctx[`XRC_W_MODES][`XRC_M_PRG_FLAG] <= 1'b1;
            end
            state <= S_XWAIT;
          end else if (memRvalid) begin
            ibuf[fIdx] <= memRdata;
            fIdx <= fIdx + {{(BUF_LOG-1){1'b0}}, 1'b1};
            if (&fIdx) begin
              bufTag <= blockWord;
              bufValid <= 1'b1;
              state <= S_RUN;
            end else begin
              state <= S_FETCH;
            end
          end
        end
        S_RUN: begin
          dataReady <= 1'b1;
          if (dataReq) begin
            dataReady <= 1'b0;
            if (!dataOk && oprMode) begin
              ctx[`XRC_W_MODES][`XRC_M_OPR_FLAG] <= 1'b1;
              pendX <= modes[`XRC_M_EIM];
            end
            if (dataWe) begin
              memReq <= dataOk;
              memWe <= dataOk;
              memAddr <= dataAbs;
              memWdata <= dataWdata;
              if (!dataOk && oprMode && modes[`XRC_M_EIM]) begin
                state <= S_XWAIT;
              end
            end else begin
              memReq <= 1'b1;
              memAddr <= dataAbs;
              dZero <= !dataOk;
              state <= S_DWAIT;
            end
          end else if (!present) begin
            fIdx <= {BUF_LOG{1'b0}};
            dataReady <= 1'b0;
            state <= S_FETCH;
          end else if (issueReady) begin
            issueValid <= 1'b1;
            issueParcel <= curWord[pc[1:0]*16 +: 16];
            ctx[`XRC_W_PC][31:0] <= pcNext;
          end
        end
        S_DWAIT: begin
          if (memRvalid) begin
            dataRvalid <= 1'b1;
            dataRdata <= dZero ? 64'h0000_0000_0000_0000 : memRdata;
            state <= pendX ? S_XWAIT : S_RUN;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // exchange_and_range_check

// ==== sim/central_memory_model.sv ====
`timescale 1ns/10ps
// ==========
// memory side: never stalls, one read at a time, lat sets answer delay
module central_memory_model (
  input wire clk,
  input wire memReq,
  input wire memWe,
  input wire [31:0] memAddr,
  input wire [63:0] memWdata,
  input wire [3:0] lat,
  output logic memRvalid,
  output logic [63:0] memRdata
);
  logic [63:0] mem [0:255];
  logic [63:0] pend;
  int cnt = 0;
  int nRd = 0;
  int nWr = 0;
  initial memRvalid = 0;
  initial memRdata = '0;
  always @(posedge clk) begin
    memRvalid <= cnt == 1;
    // idle data bus toggles so a stale word never looks like an answer
    memRdata <= cnt == 1 ? pend : ~memRdata;
    if (cnt > 0) cnt <= cnt - 1;
    if (memReq && memWe) begin
      mem[memAddr[7:0]] <= memWdata;
      nWr <= nWr + 1;
    end
    if (memReq && !memWe) begin
      pend <= mem[memAddr[7:0]];
      cnt <= lat + 1;
      nRd <= nRd + 1;
    end
  end
endmodule // central_memory_model

// ==== sim/exchange_and_range_check_checker.sv ====
`timescale 1ns/10ps
module exchange_and_range_check_checker (
  input wire clk,
  input wire reset,
  input wire memReq,
  input wire memWe,
  input wire memRvalid,
  input wire [63:0] memRdata,
  input wire issueReady,
  input wire issueValid,
  input wire dataReq,
  input wire dataWe,
  input wire dataReady,
  input wire dataRvalid,
  input wire [63:0] dataRdata,
  input wire pclkIrq,
  input wire iprocIrq,
  input wire irqOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  quietStart_a: assert property ($fell(reset) |-> !memReq && !issueValid && !irqOut)
    else $error("activity right after reset");
  memPulse_a: assert property (memReq && !memWe |=> !memReq)
    else $error("memory request held");
  issueGate_a: assert property (issueValid |-> $past(issueReady))
    else $error("issue without ready");
  readIssues_a: assert property (dataReq && dataReady && !dataWe |=> memReq && !memWe)
    else $error("data read not sent");
  readyDrop_a: assert property (dataReq && dataReady |=> !dataReady)
    else $error("ready kept after request");
  answerAfter_a: assert property (dataRvalid |-> $past(memRvalid))
    else $error("data answer without memory answer");
  zeroOrMem_a: assert property (dataRvalid |-> dataRdata == 0 || dataRdata == $past(memRdata))
    else $error("read data neither zero nor memory");
  clockKept_a: assert property (pclkIrq |-> ##2 irqOut)
    else $error("clock interrupt not raised");
  procKept_a: assert property (iprocIrq |-> ##2 irqOut)
    else $error("processor interrupt not raised");
endmodule // exchange_and_range_check_checker
bind exchange_and_range_check exchange_and_range_check_checker chk_u (.clk(clk), .reset(reset),
  .memReq(memReq), .memWe(memWe), .memRvalid(memRvalid), .memRdata(memRdata),
  .issueReady(issueReady), .issueValid(issueValid), .dataReq(dataReq), .dataWe(dataWe),
  .dataReady(dataReady), .dataRvalid(dataRvalid), .dataRdata(dataRdata),
  .pclkIrq(pclkIrq), .iprocIrq(iprocIrq), .irqOut(irqOut));

// ==== sim/test_exchange_and_range_check.sv ====
`timescale 1ns/10ps
module test_exchange_and_range_check;
  localparam int LIM = 3000;
  logic clk = 0, reset = 1, wr = 0, rd = 0, memReq, memWe, memRvalid, issueValid;
  logic computeBusy = 1, issueReady = 0, dataReq = 0, dataWe = 0, dataReady, dataRvalid;
  logic pclkIrq = 0, iprocIrq = 0, irqOut;
  logic [7:0] addr = '0;
  logic [3:0] lat = '0;
  logic [15:0] issueParcel;
  logic [31:0] wdata = '0, dataAddr = '0, rdata, memAddr;
  logic [63:0] memWdata, memRdata, dataWdata = '0, dataRdata, ctx [0:15], nxt [0:15];
  int errorCnt = 0, nChecks = 0;
  always #2 clk = ~clk;
  exchange_and_range_check dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRvalid(memRvalid), .memRdata(memRdata),
    .computeBusy(computeBusy), .issueReady(issueReady), .issueValid(issueValid),
    .issueParcel(issueParcel), .dataReq(dataReq), .dataWe(dataWe), .dataAddr(dataAddr),
    .dataWdata(dataWdata), .dataReady(dataReady), .dataRvalid(dataRvalid),
    .dataRdata(dataRdata), .pclkIrq(pclkIrq), .iprocIrq(iprocIrq), .irqOut(irqOut));
  central_memory_model mem_u (.clk(clk), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .lat(lat), .memRvalid(memRvalid), .memRdata(memRdata));
  // ==========
  // tasks
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
  endtask
  task automatic finalReport;
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(logic [63:0] g, logic [63:0] e);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic guard(int k);
    if (k >= LIM) begin
      errorCnt++;
      $display("MISMATCH t=%0t wait ran out", $time);
      finalReport;
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    wr <= 1; addr <= a; wdata <= d;
    tick(); wr <= 0;
    tick();
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rreg(logic [7:0] a, output logic [63:0] g);
    rd <= 1; addr <= a;
    tick(); rd <= 0;
    tick(); g = 64'(rdata);
  endtask
  task automatic wctx(int i, logic [63:0] v);
    wreg(8'(8'h80 + 8 * i), v[31:0]);
    wreg(8'(8'h84 + 8 * i), v[63:32]);
  endtask
  task automatic rctx(int i, output logic [63:0] g);
    logic [63:0] h;
    rreg(8'(8'h80 + 8 * i), g);
    rreg(8'(8'h84 + 8 * i), h);
    g = {h[31:0], g[31:0]};
  endtask
  // request raised after ready is seen high at a falling edge, then held for one clock
  task automatic dref(logic we, logic [31:0] a, logic [63:0] d, output logic [63:0] g);
    int k;
    for (k = 0; k < LIM; k++) begin
      @(negedge clk);
      if (dataReady === 1) break;
    end
    guard(k);
    @(posedge clk);
    dataReq <= 1; dataWe <= we; dataAddr <= a; dataWdata <= d;
    tick(); dataReq <= 0;
    for (k = 0; k < LIM && !we; k++) begin
      @(negedge clk);
      if (dataRvalid === 1) break;
    end
    guard(k);
    g = dataRdata;
    tick(2);
  endtask
  // ==========
  // sequence
  initial begin
    logic [63:0] g;
    int k;
    tick(10);
    reset <= 0;
    tick();
    for (int i = 0; i < 16; i++) begin
      ctx[i] = i < 7 ? i : 64'hc0de_0000_0000_0000 + i;
      nxt[i] = 64'h7a11_0000_0000_0000 + i;
    end
    ctx[5] = 64'h40;
    nxt[0] = 1; nxt[1] = 64'h10; nxt[2] = 64'h17; nxt[3] = 64'h80;
    nxt[4] = 64'h8f; nxt[5] = 64'h40; nxt[6] = 64'h8;
    for (int i = 0; i < 16; i++) begin
      mem_u.mem[8'h40 + i] = nxt[i];
      wctx(i, ctx[i]);
    end
    mem_u.mem[8'h10] = 64'h4444_3333_2222_1111;
    mem_u.mem[8'h85] = 64'h77;
    mem_u.mem[8'ha0] = 64'h5a5a;
    wreg(8'h00, 32'h1);
    tick(20);
    chk(mem_u.nRd, 0);
    computeBusy <= 0;
    lat <= 4'h3;
    for (k = 0; k < LIM && mem_u.nRd < 24; k++) tick();
    guard(k);
    tick(8);
    chk(mem_u.nWr, 16);
    chk(mem_u.nRd, 24);
    for (int i = 0; i < 16; i++) begin
      chk(mem_u.mem[8'h40 + i], ctx[i]);
      rctx(i, g);
      chk(g, i == 6 ? nxt[6] | 64'h10 : nxt[i]);
    end
    $display("exchange test done");
    issueReady <= 1;
    tick(); issueReady <= 0;
    for (k = 0; k < LIM; k++) begin
      @(negedge clk);
      if (issueValid === 1) break;
    end
    guard(k);
    chk(issueParcel, 16'h2222);
    @(posedge clk);
    dref(1, 32'hf, 64'hbeef, g);
    chk(mem_u.mem[8'h8f], 64'hbeef);
    dref(1, 32'h20, 64'hdead, g);
    chk(mem_u.mem[8'ha0], 64'h5a5a);
    chk(mem_u.nWr, 17);
    dref(0, 32'h5, 0, g);
    chk(g, 64'h77);
    dref(0, 32'h20, 0, g);
    chk(g, 0);
    chk(mem_u.nRd, 26);
    chk(irqOut, 0);
    $display("range test done");
    pclkIrq <= 1; iprocIrq <= 1;
    tick(); pclkIrq <= 0; iprocIrq <= 0;
    tick(3);
    chk(irqOut, 1);
    rreg(8'h08, g);
    chk(g, 64'hc);
    wreg(8'h00, 32'h6);
    tick(3);
    chk(irqOut, 0);
    $display("interrupt test done");
    finalReport;
  end
endmodule // test_exchange_and_range_check
